// file: design/rs232_pd_pkg.sv
// Constants, field layouts and types for the RS-232 powerdown controller.
// Assumes a single 200 MHz clock; all times are counted in 1 us ticks.
package rs232_pd_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_S   = 1000000000 / TICK_NS;

  // Documented times, each in its own unit
  localparam int unsigned AUTO_PD_S = 30;
  localparam int unsigned WAKE_US   = 100;
  localparam int unsigned INVL_US   = 30;
  localparam int unsigned INVH_US   = 1;

  // Derived tick counts (defaults of the top-level parameters; INVH_TICKS is fixed)
  localparam int unsigned AUTO_PD_TICKS_DEF = AUTO_PD_S * TICKS_PER_S;
  localparam int unsigned WAKE_TICKS_DEF    = WAKE_US * 1000 / TICK_NS;
  localparam int unsigned INVL_TICKS_DEF    = INVL_US * 1000 / TICK_NS;
  localparam int unsigned INVH_TICKS        = INVH_US * 1000 / TICK_NS;

  // Channel counts
  localparam int unsigned N_TX        = 3;
  localparam int unsigned N_RX        = 5;
  localparam int unsigned MONITOR_SRC = 0;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS       = 4'h0;
  localparam logic [3:0] STATUS_OFS     = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS   = 4'hc;

  // Field positions
  localparam int unsigned CTRL_SOFT_PD = 0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_EXPIRED   = 2;
  localparam int unsigned ST_INVALID_N = 3;
  localparam int unsigned ST_KILL      = 4;
  localparam int unsigned ST_HOLD      = 5;
  localparam int unsigned IRQ_PD       = 0;
  localparam int unsigned IRQ_READY    = 1;
  localparam int unsigned IRQ_INV_FELL = 2;
  localparam int unsigned IRQ_INV_ROSE = 3;
  localparam int unsigned IRQ_W        = 4;

  // Reset values
  localparam logic             CTRL_RST     = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    ST_MANUAL = 2'b00,
    ST_AUTO   = 2'b01,
    ST_WAKING = 2'b10,
    ST_ACTIVE = 2'b11
  } power_state_type;

  typedef struct packed {
    logic [N_TX-1:0] tx;
    logic [N_RX-1:0] rx;
  } line_type;

  typedef struct packed {
    logic            charge_pump;
    logic [N_TX-1:0] tx;
    logic [N_RX-1:0] rx;
    logic            monitor;
  } out_en_type;

endpackage : rs232_pd_pkg

// file: design/rs232_powerdown_control.sv
// Power-state controller for a multi-channel RS-232 transceiver.
// Assumes digitised threshold and valid-level inputs from the analog side,
// asynchronous to mclk, and an Avalon-MM master on mclk.
// What this block does
// R1: Powerdown places all transmitters high impedance
// R2: Monitor receiver output always enabled
// R3: Inverting receivers off only in manual powerdown
// R4: Hold-on and kill high keep device active while soft_pd is clear
// R5: Thirty seconds without edges powers down transmitters
// R6: Kill low forces manual powerdown
// R7: Transmitters ready about 100 us after wake
// R8: Manual powerdown exit needs both high or edge
// R9: Hold-on falling edge restarts full window
// R10: Tying controls together gives plain shutdown
// R11: Charge pump disabled in every powerdown state
// R12: Host toggles kill; both high always on while soft_pd is clear
// R13: Invalid flag on both controls forces powerdown
// R14: Activity is any input threshold crossing
// R15: Invalid flag low after 30 us invalid
// R16: Invalid flag high 1 us after valid
// R17: Timer stays expired until edge, hold-on edge or hold-on high
// R18: Timer counts ticks, reloads on edges
`timescale 1ns/100ps
module rs232_powerdown_control #(
  parameter int unsigned AUTO_PD_TICKS = rs232_pd_pkg::AUTO_PD_TICKS_DEF,
  parameter int unsigned WAKE_TICKS    = rs232_pd_pkg::WAKE_TICKS_DEF,
  parameter int unsigned INVL_TICKS    = rs232_pd_pkg::INVL_TICKS_DEF
) (
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  input  wire logic                           power_kill_input,
  input  wire logic                           power_hold_on_input,
  input  wire rs232_pd_pkg::line_type         line_in,
  input  wire logic [rs232_pd_pkg::N_RX-1:0]  rx_valid,
  output rs232_pd_pkg::out_en_type            out_en,
  output logic                                monitor_rx_out,
  output logic                                invalid_n,
  input  wire logic [3:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [3:0]                     avs_byteenable,
  input  wire logic [31:0]                    avs_writedata,
  output logic [31:0]                         avs_readdata,
  output logic                                avs_waitrequest,
  output logic                                irq
);
  import rs232_pd_pkg::*;

  localparam int unsigned SW = 2 + N_TX + N_RX + N_RX;

  logic [SW-1:0]   sync1;
  logic [SW-1:0]   sync2;
  logic [SW-1:0]   sync3;
  logic            kill_s;
  logic            hold_s;
  logic            hold_rise;
  logic            hold_fall;
  logic            activity;
  logic            any_valid;
  logic            manual_pd;
  logic [7:0]      pre;
  logic [7:0]      next_pre;
  logic            tick;
  logic [31:0]     idle_cnt;
  logic [31:0]     next_idle_cnt;
  logic            expired;
  logic            next_expired;
  power_state_type state;
  power_state_type next_state;
  logic [31:0]     wake_cnt;
  logic [31:0]     next_wake_cnt;
  out_en_type      next_out_en;
  logic [31:0]     inv_cnt;
  logic [31:0]     next_inv_cnt;
  logic            next_invalid_n;
  logic            ack;
  logic            soft_pd;
  logic            next_soft_pd;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [IRQ_W-1:0] events;
  logic [31:0]     next_readdata;
  logic            wr_go;

  // Two-stage synchronisers; third stage only feeds the edge detectors.
  // Control bits reset to the always-on strap level, so leaving reset
  // shows no false kill and no false hold-on edge.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      sync1 <= {2'b11, {(SW-2){1'b0}}};
      sync2 <= {2'b11, {(SW-2){1'b0}}};
      sync3 <= {2'b11, {(SW-2){1'b0}}};
    end
    else
    begin
      sync1 <= {power_kill_input, power_hold_on_input, line_in, rx_valid};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Decoded control levels and edges
  assign kill_s    = sync2[SW-1];
  assign hold_s    = sync2[SW-2];
  assign hold_rise = hold_s & ~sync3[SW-2];
  assign hold_fall = ~hold_s & sync3[SW-2];
  assign any_valid = |sync2[N_RX-1:0];
  // R14: either-direction threshold crossing
  assign activity  = |(sync2[SW-3:N_RX] ^ sync3[SW-3:N_RX]);
  // R6: kill low dominates everything
  // R13: flag-driven pins act through kill
  assign manual_pd = ~kill_s | soft_pd;

  // Time base and inactivity timer
  always_comb
  begin
    next_pre      = (pre == 8'(TICK_CYCLES - 1)) ? 8'h00 : pre + 8'h01;
    next_idle_cnt = idle_cnt;
    next_expired  = expired;
    // R18: reload on edge or hold-on rise
    // R9: hold-on fall restarts full window
    if (activity || hold_rise || hold_fall)
    begin
      next_idle_cnt = 32'h0;
      next_expired  = 1'b0;
    end
    // R17: manual powerdown leaves timer expired
    else if (manual_pd)
      next_expired = 1'b1;
    // R4: hold-on high disables auto powerdown
    else if (hold_s)
    begin
      next_idle_cnt = 32'h0;
      next_expired  = 1'b0;
    end
    // R5: count ticks to the inactivity limit
    else if (!expired && tick)
    begin
      next_idle_cnt = idle_cnt + 32'h1;
      if (next_idle_cnt >= AUTO_PD_TICKS)
        next_expired = 1'b1;
    end
  end

  assign tick = (pre == 8'(TICK_CYCLES - 1));

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pre      <= 8'h00;
      idle_cnt <= 32'h0;
      expired  <= 1'b0;
    end
    else
    begin
      pre      <= next_pre;
      idle_cnt <= next_idle_cnt;
      expired  <= next_expired;
    end
  end

  // Power state machine; outputs registered from the next state
  always_comb
  begin
    next_state    = state;
    next_wake_cnt = 32'h0;
    case (state)
      ST_MANUAL, ST_AUTO:
        // R8: leave only once hold is high or timer cleared
        if (!manual_pd && (hold_s || !expired))
          next_state = ST_WAKING;
        else
          next_state = manual_pd ? ST_MANUAL : ST_AUTO;
      ST_WAKING:
      begin
        next_wake_cnt = wake_cnt + (tick ? 32'h1 : 32'h0);
        // R7: pump settles before transmitters enable
        if (next_wake_cnt >= WAKE_TICKS)
          next_state = ST_ACTIVE;
      end
      ST_ACTIVE:
        next_state = ST_ACTIVE;
      default:
        next_state = ST_MANUAL;
    endcase
    if (manual_pd)
      next_state = ST_MANUAL;
    else if (!hold_s && next_expired && state != ST_MANUAL)
      next_state = ST_AUTO;
    if (next_state != ST_WAKING)
      next_wake_cnt = 32'h0;
    // R11: pump off in every powerdown
    next_out_en.charge_pump = (next_state == ST_WAKING) ||
                              (next_state == ST_ACTIVE);
    // R1: transmitters only driven when active
    next_out_en.tx = (next_state == ST_ACTIVE) ? '1 : '0;
    // R3: inverting receivers off in manual only
    next_out_en.rx = (next_state == ST_MANUAL) ? '0 : '1;
    // R2: monitor receiver never disabled
    next_out_en.monitor = 1'b1;
  end

  // Reset starts the pump so the link comes up on its own
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state          <= ST_WAKING;
      wake_cnt       <= 32'h0;
      out_en         <= '{charge_pump: 1'b1, tx: '0, rx: '1, monitor: 1'b1};
      monitor_rx_out <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      wake_cnt       <= next_wake_cnt;
      out_en         <= next_out_en;
      monitor_rx_out <= sync2[N_RX + MONITOR_SRC];
    end
  end

  // Signal-invalid detector, runs in every power mode
  always_comb
  begin
    next_inv_cnt   = 32'h0;
    next_invalid_n = invalid_n;
    if (any_valid != invalid_n)
    begin
      next_inv_cnt = inv_cnt + (tick ? 32'h1 : 32'h0);
      // R15: low after 30 us of invalid levels
      // R16: high 1 us after a valid level
      if (next_inv_cnt >= (any_valid ? INVH_TICKS : INVL_TICKS))
      begin
        next_invalid_n = any_valid;
        next_inv_cnt   = 32'h0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      inv_cnt   <= 32'h0;
      invalid_n <= 1'b0;
    end
    else
    begin
      inv_cnt   <= next_inv_cnt;
      invalid_n <= next_invalid_n;
    end
  end

  // Interrupt sources, one-cycle pulses
  assign events[IRQ_PD]       = (next_state == ST_MANUAL ||
                                 next_state == ST_AUTO) &&
                                (state == ST_WAKING || state == ST_ACTIVE);
  assign events[IRQ_READY]    = next_state == ST_ACTIVE &&
                                state != ST_ACTIVE;
  assign events[IRQ_INV_FELL] = invalid_n & ~next_invalid_n;
  assign events[IRQ_INV_ROSE] = ~invalid_n & next_invalid_n;

  // Avalon slave: one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go           = avs_write & ack & avs_byteenable[0];
  assign irq             = |(irq_status & irq_mask);

  always_comb
  begin
    next_soft_pd    = soft_pd;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    next_readdata   = avs_readdata;
    if (wr_go && avs_address == CTRL_OFS)
      next_soft_pd = avs_writedata[CTRL_SOFT_PD];
    if (wr_go && avs_address == IRQ_MASK_OFS)
      next_irq_mask = avs_writedata[IRQ_W-1:0];
    if (wr_go && avs_address == IRQ_STATUS_OFS)
      next_irq_status = irq_status & ~avs_writedata[IRQ_W-1:0];
    // Set wins over a simultaneous clear
    next_irq_status = next_irq_status | events;
    if (avs_read && !ack)
    begin
      next_readdata = 32'h0;
      case (avs_address)
        CTRL_OFS:
          next_readdata[CTRL_SOFT_PD] = soft_pd;
        STATUS_OFS:
        begin
          next_readdata[ST_STATE_LSB +: 2] = state;
          next_readdata[ST_EXPIRED]        = expired;
          next_readdata[ST_INVALID_N]      = invalid_n;
          next_readdata[ST_KILL]           = kill_s;
          next_readdata[ST_HOLD]           = hold_s;
        end
        IRQ_STATUS_OFS:
          next_readdata[IRQ_W-1:0] = irq_status;
        IRQ_MASK_OFS:
          next_readdata[IRQ_W-1:0] = irq_mask;
        default:
          next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ack          <= 1'b0;
      soft_pd      <= CTRL_RST;
      irq_mask     <= IRQ_MASK_RST;
      irq_status   <= '0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack          <= (avs_read | avs_write) & ~ack;
      soft_pd      <= next_soft_pd;
      irq_mask     <= next_irq_mask;
      irq_status   <= next_irq_status;
      avs_readdata <= next_readdata;
    end
  end

  // Checks: helper counter of cycles spent waking
  logic [31:0] wake_cyc;
  always_ff @(posedge mclk)
  begin
    if (!rstn || state != ST_WAKING)
      wake_cyc <= 32'h0;
    else
      wake_cyc <= wake_cyc + 32'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_TX_OFF_IN_PD: assert property ( // R1
    state != ST_ACTIVE |-> out_en.tx == '0)
    else $error("transmitter enabled outside active state");
  AST_MONITOR_ON: assert property ( // R2
    out_en.monitor && $stable(out_en.monitor))
    else $error("monitor receiver disabled");
  AST_RX_MODES: assert property ( // R3
    (state == ST_MANUAL |-> out_en.rx == '0) and
    (state == ST_AUTO |-> out_en.rx == '1))
    else $error("receiver enables wrong for powerdown kind");
  AST_HOLD_ACTIVE: assert property ( // R4
    (kill_s && hold_s && !soft_pd) [*2] |-> state != ST_AUTO)
    else $error("auto powerdown while hold-on high");
  AST_EXPIRE_PD: assert property ( // R5
    kill_s && !hold_s && !soft_pd && expired && !activity && !hold_fall
    |=> state == ST_AUTO)
    else $error("no auto powerdown after timer expiry");
  AST_KILL_FORCES: assert property ( // R6
    !kill_s |=> state == ST_MANUAL && out_en.tx == '0)
    else $error("kill low did not force manual powerdown");
  AST_WAKE_TIME: assert property ( // R7
    state == ST_WAKING |->
      wake_cyc < (WAKE_TICKS + 1) * TICK_CYCLES)
    else $error("wake-up took longer than the wake window");
  AST_MANUAL_EXIT: assert property ( // R8
    state == ST_MANUAL && kill_s && !soft_pd && !hold_s && expired &&
    !activity && !hold_fall |=> state == ST_AUTO)
    else $error("left manual powerdown without edge or hold-on");
  AST_HOLD_FALL: assert property ( // R9
    hold_fall && kill_s && !soft_pd ##1 !activity |-> !expired [*2])
    else $error("hold-on fall did not restart the window");
  AST_PUMP_OFF: assert property ( // R11
    (state == ST_MANUAL || state == ST_AUTO) |-> !out_en.charge_pump)
    else $error("charge pump on during powerdown");
  AST_EXPIRED_HOLDS: assert property ( // R17
    expired && !activity && !hold_rise && !hold_fall |=> expired)
    else $error("expired timer cleared without cause");
  AST_EDGE_RELOAD: assert property ( // R18
    activity |=> !expired && idle_cnt == 32'h0)
    else $error("edge did not reload the timer");
  AST_INV_FALL: assert property ( // R15
    $fell(invalid_n) |-> !$past(any_valid))
    else $error("invalid flag fell with a valid level present");
  AST_INV_RISE: assert property ( // R16
    $rose(invalid_n) |-> $past(any_valid))
    else $error("invalid flag rose without a valid level");

  COV_AUTO_PD: cover property (state == ST_ACTIVE ##1 state == ST_AUTO);
  COV_MANUAL: cover property (state == ST_ACTIVE ##1 state == ST_MANUAL);
  COV_WAKE: cover property (state == ST_WAKING ##1 state == ST_ACTIVE);
  COV_INV: cover property ($rose(invalid_n));

endmodule : rs232_powerdown_control

// file: test/host_pm.sv
// Host power-management model that drives the two control pins.
// Assumes the bench picks a wiring mode just after a rising edge.
`timescale 1ns/100ps
module host_pm (
  input  wire logic       mclk,
  input  wire logic [1:0] mode,
  input  wire logic       kill_req,
  input  wire logic       hold_req,
  input  wire logic       invalid_n,
  output logic            power_kill_input,
  output logic            power_hold_on_input
);
  // Pins start in always-on strapping before the first edge
  initial
  begin
    power_kill_input    = 1'b1;
    power_hold_on_input = 1'b1;
  end

  // Pins move only after a rising edge, like registered glue logic
  always @(posedge mclk)
  begin
    case (mode)
      2'd1:
      begin
        power_kill_input    <= kill_req;
        power_hold_on_input <= kill_req;
      end
      2'd2:
      begin
        power_kill_input    <= invalid_n;
        power_hold_on_input <= invalid_n;
      end
      default:
      begin
        power_kill_input    <= kill_req;
        power_hold_on_input <= hold_req;
      end
    endcase
  end
endmodule : host_pm

// file: test/rs232_powerdown_control_tb.sv
// Self-checking bench for the powerdown controller, with shortened timers.
// Assumes the host model drives the control pins; bench drives the rest.
`timescale 1ns/100ps
module rs232_powerdown_control_tb;
  import rs232_pd_pkg::*;
  localparam int AUTO = 20;
  localparam int WAKE = 3;
  localparam int INVL = 4;
  localparam int T    = TICK_CYCLES;

  logic        mclk           = 1'b0;
  logic        rstn           = 1'b0;
  logic [1:0]  mode           = 2'd1;
  logic        kill_req       = 1'b1;
  logic        hold_req       = 1'b1;
  line_type    line_in        = '0;
  logic [4:0]  rx_valid       = 5'h1f;
  logic [3:0]  avs_address    = 4'h0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic        power_kill_input;
  logic        power_hold_on_input;
  out_en_type  out_en;
  logic        monitor_rx_out;
  logic        invalid_n;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  int          errors         = 0;
  int          n_checks       = 0;

  always #2.5 mclk = ~mclk;

  rs232_powerdown_control #(.AUTO_PD_TICKS(AUTO), .WAKE_TICKS(WAKE),
    .INVL_TICKS(INVL)) dut (.mclk(mclk), .rstn(rstn),
    .power_kill_input(power_kill_input),
    .power_hold_on_input(power_hold_on_input), .line_in(line_in),
    .rx_valid(rx_valid), .out_en(out_en), .monitor_rx_out(monitor_rx_out),
    .invalid_n(invalid_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

  host_pm host (.mclk(mclk), .mode(mode), .kill_req(kill_req),
    .hold_req(hold_req), .invalid_n(invalid_n),
    .power_kill_input(power_kill_input),
    .power_hold_on_input(power_hold_on_input));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Outputs are sampled mid-cycle, where they have settled
  task automatic probe(input int sel, input logic [31:0] exp);
    logic [31:0] got;
    @(negedge mclk);
    case (sel)
      0: got = 32'(out_en);
      1: got = 32'(irq);
      2: got = 32'(invalid_n);
      3: got = 32'(monitor_rx_out);
      default: got = 32'(out_en.tx);
    endcase
    chk(got, exp);
    @(posedge mclk);
  endtask : probe

  // Bounded wait for the tx enables (sel 4) or the invalid flag (sel 2)
  task automatic await(input int sel, input logic [31:0] exp, input int lim);
    int          n;
    logic [31:0] got;
    n = 0;
    do
    begin
      @(negedge mclk);
      got = (sel == 2) ? 32'(invalid_n) : 32'(out_en.tx);
      n++;
    end
    while (got !== exp && n < lim);
    chk(got, exp);
    @(posedge mclk);
  endtask : await

  // One Avalon transfer; waitrequest and read data are taken at the edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    chk(32'(avs_waitrequest), 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask : rd_chk

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Watchdog: the whole sequence needs roughly 100 us
  initial
  begin
    #400000;
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    probe(0, 32'h23f);
    rd_chk(IRQ_MASK_OFS, 32'hffffffff, 32'(IRQ_MASK_RST));
    rd_chk(CTRL_OFS, 32'hffffffff, 32'(CTRL_RST));
    wr(4'h2, 32'hffffffff);
    rd_chk(4'h2, 32'hffffffff, 32'h0);
    wr(IRQ_MASK_OFS, 32'h3);
    rd_chk(IRQ_MASK_OFS, 32'hffffffff, 32'h3);
    await(4, 32'h7, (WAKE + 2) * T);
    probe(1, 32'h1);
    wr(IRQ_STATUS_OFS, 32'h3);
    probe(1, 32'h0);
    // Tied pins held high: no inactivity powerdown
    cyc((AUTO + 5) * T);
    probe(0, 32'h3ff);
    kill_req <= 1'b0;
    cyc(10);
    probe(0, 32'h001);
    line_in.rx[0] <= 1'b1;
    cyc(6);
    probe(3, 32'h1);
    probe(1, 32'h1);
    rd_chk(STATUS_OFS, 32'h7, 32'h4);
    wr(IRQ_STATUS_OFS, 32'h1);
    wr(IRQ_MASK_OFS, 32'h0);
    // Kill released with hold low and no edge: stays down
    mode     <= 2'd0;
    hold_req <= 1'b0;
    kill_req <= 1'b1;
    cyc(5 * T);
    probe(0, 32'h03f);
    probe(1, 32'h0);
    line_in.tx[0] <= 1'b1;
    cyc(2 * T - 20);
    probe(4, 32'h0);
    await(4, 32'h7, 2 * T + 40);
    cyc(14 * T);
    probe(4, 32'h7);
    line_in.rx[2] <= 1'b1;
    cyc(10 * T);
    probe(4, 32'h7);
    await(4, 32'h0, 12 * T);
    probe(0, 32'h03f);
    rd_chk(STATUS_OFS, 32'h7, 32'h5);
    rd_chk(IRQ_STATUS_OFS, 32'h1, 32'h1);
    hold_req <= 1'b1;
    await(4, 32'h7, (WAKE + 3) * T);
    hold_req <= 1'b0;
    cyc(16 * T);
    probe(4, 32'h7);
    await(4, 32'h0, 8 * T);
    // Invalid flag wired to both pins
    mode <= 2'd2;
    await(4, 32'h7, (WAKE + 3) * T);
    rx_valid <= 5'h0;
    cyc((INVL - 1) * T - 20);
    probe(2, 32'h1);
    await(2, 32'h0, 2 * T + 60);
    cyc(10);
    probe(0, 32'h001);
    rx_valid[3] <= 1'b1;
    await(2, 32'h1, 2 * T + 20);
    await(4, 32'h7, (WAKE + 3) * T);
    wrap_up();
  end
endmodule : rs232_powerdown_control_tb
